// ---- rtl/dmpp_pkg.sv ----
/*
  Constants for the drive mode parameter and policy block: page layout,
  writable masks, reset images, field positions and timing figures.
  Assumes the parameter bytes are addressed by page code and byte index.
*/
package dmpp_pkg;
  // ==========================================================
  // Page identity and layout
  localparam logic [7:0] PG_VENDOR = 8'h00;
  localparam logic [7:0] PG_RECOV  = 8'h01;
  localparam logic [7:0] PS_FLAG   = 8'h80;
  localparam logic [7:0] P0_LEN    = 8'h0e;
  localparam logic [7:0] P1_LEN    = 8'h0a;
  localparam logic [3:0] P0_LAST   = 4'hf;
  localparam logic [3:0] P1_LAST   = 4'hb;
  localparam logic [3:0] IDX_CODE  = 4'h0;
  localparam logic [3:0] IDX_LEN   = 4'h1;
  localparam logic [3:0] IDX_XBITS = 4'h3;

  // ==========================================================
  // Writable masks and reset images, byte 0 in the low bits
  localparam logic [127:0] P0_MASK =
    128'hb4ff_ffff_ffff_ff00_ffcf_1300_5009_0000;
  localparam logic [127:0] P0_RST  =
    128'h0000_1416_3000_0000_0000_0200_0000_0000;
  localparam logic [127:0] P1_MASK =
    128'h0000_0000_ffff_00ff_0000_0000_fff6_0000;
  localparam logic [127:0] P1_RST  =
    128'h0000_0000_0000_0001_0000_0000_0100_0000;

  // ==========================================================
  // Field positions inside the flat page images
  localparam int B_MERGE  = 2*8+3;
  localparam int B_XMODE  = 3*8+6;
  localparam int B_NDRPT  = 3*8+4;
  localparam int B_SUPP   = 5*8+4;
  localparam int B_QAGE   = 5*8+1;
  localparam int B_SKIP   = 6*8+7;
  localparam int B_BRR    = 6*8+6;
  localparam int B_TMRH   = 6*8;
  localparam int B_TMRL   = 7*8;
  localparam int B_TEMP   = 9*8;
  localparam int B_AGEH   = 10*8;
  localparam int B_AGEL   = 11*8;
  localparam int B_RTH    = 12*8;
  localparam int B_WTH    = 13*8;
  localparam int B_RSTDIS = 14*8+7;
  localparam int B_NOWR   = 14*8+3;
  localparam int B_CERT   = 15*8+5;
  localparam int B_CRF    = 2*8+4;
  localparam int B_POST   = 2*8+2;
  localparam int B_RRL    = 3*8;
  localparam int B_WRL    = 8*8;
  localparam int B_RTLH   = 10*8;
  localparam int B_RTLL   = 11*8;

  // ==========================================================
  // Policy values and timing
  localparam logic [7:0] TEMP_DFLT       = 8'h55;
  localparam logic [7:0] DFLT_READ_RETRY = 8'h10;
  localparam logic [3:0] SK_ABORTED      = 4'hb;
  localparam int TICK_MS       = 50;
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS     = 1000000;
  localparam int TICK_CYC_DFLT = TICK_MS*NS_PER_MS/CLK_PERIOD_NS;
  localparam int NSLOT         = 4;

  typedef enum logic [1:0] {
    RK_READ  = 2'b00,
    RK_WRITE = 2'b01,
    RK_NDATA = 2'b10
  } dmpp_rk_e;

  typedef enum logic [1:0] {
    XS_IDLE  = 2'b00,
    XS_ARMED = 2'b01,
    XS_STOP  = 2'b10,
    XS_RUN   = 2'b11
  } dmpp_xs_e;
endpackage

// ---- rtl/dmpp_top.sv ----
/*
  Mode parameter pages 00h and 01h with the policy logic they steer:
  queue aging, overall command timer, recovered error posting, format
  and reassign options, self-seek exercise and temperature warning.
  Assumes mode select/sense bytes arrive one per cycle on the par_ port
  and that event inputs are single-cycle pulses synchronous to clk_sys.
*/
`timescale 1ns/1ps
module dmpp_top
  import dmpp_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYC_DFLT
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // Mode parameter access
  input  wire logic        par_wr,
  input  wire logic [7:0]  par_page,
  input  wire logic [3:0]  par_idx,
  input  wire logic [7:0]  par_wdata,
  output logic      [7:0]  par_rdata,
  // Spindle events
  input  wire logic        spinning,
  input  wire logic        spin_stop,
  input  wire logic        spin_start,
  // Command queue
  input  wire logic        q_push,
  input  wire logic [1:0]  q_push_slot,
  input  wire logic        q_pop,
  input  wire logic [1:0]  q_pop_slot,
  output logic             q_fifo_mode,
  output logic      [1:0]  q_fifo_slot,
  // Active read/write command
  input  wire logic        cmd_start,
  input  wire logic        cmd_rw,
  input  wire logic        cmd_done,
  output logic             cmd_abort,
  output logic      [3:0]  cmd_sense_key,
  // Recovered error events
  input  wire logic        rec_evt,
  input  wire logic [1:0]  rec_kind,
  input  wire logic [7:0]  rec_step,
  output logic             rec_post,
  // Status inputs
  input  wire logic        fmt_degraded,
  input  wire logic        cmd_is_tur,
  input  wire logic [7:0]  temp_c,
  // Policy outputs
  output logic             tur_report_degraded,
  output logic             temp_warn,
  output logic             fmt_merge,
  output logic             fmt_no_write,
  output logic             fmt_certify,
  output logic             reassign_restore,
  output logic             skip_reassigned,
  output logic             seek_exercise,
  output logic      [7:0]  read_retry_max,
  output logic      [7:0]  write_retry_max,
  output logic      [15:0] recovery_time_limit
);

  function automatic logic [7:0] byte_of(logic [127:0] v,
                                         logic [3:0] i);
    return v[{i, 3'b000} +: 8];
  endfunction

  // ==========================================================
  // Parameter pages
  logic [127:0] p0_ff;
  logic [127:0] p1_ff;
  logic [7:0]   nxt_rdata;
  logic         p0_wr;
  logic         p1_wr;
  logic [7:0]   m0;
  logic [7:0]   m1;

  assign p0_wr = par_wr && (par_page == PG_VENDOR);
  assign p1_wr = par_wr && (par_page == PG_RECOV)
                 && (par_idx <= P1_LAST);
  assign m0 = byte_of(P0_MASK, par_idx);
  assign m1 = byte_of(P1_MASK, par_idx);

  // Ignored bits sit in the mask so they read back, but no logic uses them
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      p0_ff <= P0_RST;
    end else if (p0_wr) begin
      p0_ff[{par_idx, 3'b000} +: 8] <=
        (byte_of(p0_ff, par_idx) & ~m0) | (par_wdata & m0);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      p1_ff <= P1_RST;
    end else if (p1_wr) begin
      p1_ff[{par_idx, 3'b000} +: 8] <=
        (byte_of(p1_ff, par_idx) & ~m1) | (par_wdata & m1);
    end
  end

  // Unknown pages and indices beyond the page read as zero
  always_comb begin
    nxt_rdata = '0;
    if (par_page == PG_VENDOR || (par_page == PG_RECOV
                                  && par_idx <= P1_LAST)) begin
      if (par_idx == IDX_CODE) begin
        nxt_rdata = PS_FLAG | par_page;
      end else if (par_idx == IDX_LEN) begin
        nxt_rdata = (par_page == PG_VENDOR) ? P0_LEN : P1_LEN;
      end else begin
        nxt_rdata = (par_page == PG_VENDOR) ? byte_of(p0_ff, par_idx)
                                            : byte_of(p1_ff, par_idx);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      par_rdata <= '0;
    end else begin
      par_rdata <= nxt_rdata;
    end
  end

  // Field views
  logic        f_merge, f_xmode, f_ndrpt, f_supp, f_qage, f_skip;
  logic        f_brr, f_rstdis, f_nowr, f_cert, f_crf, f_post;
  logic [11:0] f_tmr;
  logic [15:0] f_age;
  logic [7:0]  f_temp, f_rth, f_wth, f_rrl, f_wrl;

  assign f_merge  = p0_ff[B_MERGE];
  assign f_xmode  = p0_ff[B_XMODE];
  assign f_ndrpt  = p0_ff[B_NDRPT];
  assign f_supp   = p0_ff[B_SUPP];
  assign f_qage   = p0_ff[B_QAGE];
  assign f_skip   = p0_ff[B_SKIP];
  assign f_brr    = p0_ff[B_BRR];
  assign f_tmr    = {p0_ff[B_TMRH +: 4], p0_ff[B_TMRL +: 8]};
  assign f_temp   = p0_ff[B_TEMP +: 8];
  assign f_age    = {p0_ff[B_AGEH +: 8], p0_ff[B_AGEL +: 8]};
  assign f_rth    = p0_ff[B_RTH +: 8];
  assign f_wth    = p0_ff[B_WTH +: 8];
  assign f_rstdis = p0_ff[B_RSTDIS];
  assign f_nowr   = p0_ff[B_NOWR];
  assign f_cert   = p0_ff[B_CERT];
  assign f_crf    = p1_ff[B_CRF];
  assign f_post   = p1_ff[B_POST];
  assign f_rrl    = p1_ff[B_RRL +: 8];
  assign f_wrl    = p1_ff[B_WRL +: 8];

  // ==========================================================
  // 50 ms tick
  logic [22:0] tick_cnt_ff;
  logic        tick;

  assign tick = (tick_cnt_ff == 23'(TICK_CYC - 1));

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick ? '0 : tick_cnt_ff + 23'h1;
    end
  end

  // ==========================================================
  // Queue aging: per-slot age and arrival rank
  logic [NSLOT-1:0] qv_ff;
  logic [15:0]      qage_ff [NSLOT];
  logic [1:0]       qrank_ff [NSLOT];
  logic [2:0]       qcnt;
  logic [NSLOT-1:0] q_expired;
  logic [1:0]       q_oldest;

  always_comb begin
    qcnt = '0;
    q_oldest = '0;
    q_expired = '0;
    for (int i = 0; i < NSLOT; i++) begin
      q_expired[i] = qv_ff[i] && (qage_ff[i] > f_age);
      qcnt = qcnt + {2'b00, qv_ff[i]};
      if (qv_ff[i] && qrank_ff[i] == 2'b00) begin
        q_oldest = 2'(i);
      end
    end
  end

  // A pop in the same cycle lowers the rank that a push takes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      qv_ff <= '0;
      for (int i = 0; i < NSLOT; i++) begin
        qage_ff[i]  <= '0;
        qrank_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NSLOT; i++) begin
        if (q_push && q_push_slot == 2'(i)) begin
          qv_ff[i]    <= 1'b1;
          qage_ff[i]  <= '0;
          qrank_ff[i] <= 2'(qcnt - {2'b00, q_pop});
        end else if (q_pop && q_pop_slot == 2'(i)) begin
          qv_ff[i] <= 1'b0;
        end else if (qv_ff[i]) begin
          if (tick && qage_ff[i] != '1) begin
            qage_ff[i] <= qage_ff[i] + 16'h1;
          end
          if (q_pop && qrank_ff[i] > qrank_ff[q_pop_slot]) begin
            qrank_ff[i] <= qrank_ff[i] - 2'h1;
          end
        end
      end
    end
  end

  // Oldest entry is aged first, so it alone decides arrival order
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      q_fifo_mode <= 1'b0;
      q_fifo_slot <= '0;
    end else begin
      q_fifo_mode <= f_qage && (|q_expired);
      q_fifo_slot <= q_oldest;
    end
  end

  // ==========================================================
  // Overall command timer, separate from aging and block recovery
  logic        tmr_run_ff;
  logic [11:0] tmr_cnt_ff;
  logic        tmr_hit;

  assign tmr_hit = tmr_run_ff && (f_tmr != '0)
                   && (tmr_cnt_ff >= f_tmr);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tmr_run_ff    <= 1'b0;
      tmr_cnt_ff    <= '0;
      cmd_abort     <= 1'b0;
      cmd_sense_key <= '0;
    end else begin
      cmd_abort <= tmr_hit;
      if (cmd_start) begin
        tmr_run_ff <= cmd_rw;
        tmr_cnt_ff <= '0;
      end else if (cmd_done || tmr_hit) begin
        tmr_run_ff <= 1'b0;
      end else if (tmr_run_ff && tick && tmr_cnt_ff != '1) begin
        tmr_cnt_ff <= tmr_cnt_ff + 12'h1;
      end
      if (tmr_hit) begin
        cmd_sense_key <= SK_ABORTED;
      end
    end
  end

  // ==========================================================
  // Self-seek exercise sequencing
  dmpp_xs_e xs_ff;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      xs_ff <= XS_IDLE;
    end else if (!f_xmode) begin
      xs_ff <= XS_IDLE;
    end else begin
      unique case (xs_ff)
        XS_IDLE:  if (spinning) xs_ff <= XS_ARMED;
        XS_ARMED: if (spin_stop) xs_ff <= XS_STOP;
        XS_STOP:  if (spin_start) xs_ff <= XS_RUN;
        XS_RUN:   xs_ff <= XS_RUN;
      endcase
    end
  end

  // ==========================================================
  // Recovered error posting and policy outputs
  logic [7:0] temp_lim;
  logic       post_ok;

  assign temp_lim = (f_temp == '0) ? TEMP_DFLT : f_temp;

  always_comb begin
    post_ok = 1'b0;
    unique case (rec_kind)
      RK_READ:  post_ok = rec_step > f_rth;
      RK_WRITE: post_ok = rec_step > f_wth;
      RK_NDATA: post_ok = f_ndrpt;
      default:  post_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rec_post            <= 1'b0;
      tur_report_degraded <= 1'b0;
      temp_warn           <= 1'b0;
      fmt_merge           <= 1'b0;
      fmt_no_write        <= 1'b0;
      fmt_certify         <= 1'b0;
      reassign_restore    <= 1'b0;
      skip_reassigned     <= 1'b0;
      seek_exercise       <= 1'b0;
      read_retry_max      <= '0;
      write_retry_max     <= '0;
      recovery_time_limit <= '0;
    end else begin
      rec_post <= rec_evt && f_post && post_ok;
      tur_report_degraded <= fmt_degraded && cmd_is_tur
                             && !f_supp;
      temp_warn        <= temp_c >= temp_lim;
      fmt_merge        <= f_merge;
      fmt_no_write     <= f_nowr;
      fmt_certify      <= f_cert;
      reassign_restore <= !f_rstdis;
      skip_reassigned  <= f_skip && f_crf;
      seek_exercise    <= (xs_ff == XS_RUN);
      if (f_brr) begin
        read_retry_max <= f_rrl;
      end else begin
        read_retry_max <= (f_rrl != '0) ? DFLT_READ_RETRY : '0;
      end
      write_retry_max     <= f_wrl;
      recovery_time_limit <= {p1_ff[B_RTLH +: 8], p1_ff[B_RTLL +: 8]};
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  chk_skip_pair: assert property (##1 skip_reassigned ==
    $past(f_skip && f_crf)) else $error("skip mismatch");
  chk_retry_bound: assert property (f_brr |=>
    read_retry_max == $past(f_rrl)) else $error("retry bound");
  chk_retry_dflt: assert property (!f_brr && f_rrl != '0 |=>
    read_retry_max == DFLT_READ_RETRY) else $error("retry default");
  chk_tmr_cause: assert property (cmd_abort |->
    $past(tmr_run_ff && f_tmr != '0 && tmr_cnt_ff >= f_tmr))
    else $error("abort without cause");
  chk_tmr_off: assert property (f_tmr == '0 |=> !cmd_abort)
    else $error("abort while disabled");
  chk_post_read: assert property (rec_evt && rec_kind == RK_READ
    && f_post && rec_step > f_rth |=> rec_post)
    else $error("read error not posted");
  chk_post_gate: assert property (!f_post |=> !rec_post)
    else $error("posted while off");
  chk_tur_supp: assert property (f_supp |=>
    !tur_report_degraded) else $error("degraded shown");
  chk_temp_dflt: assert property (f_temp == '0 &&
    temp_c >= TEMP_DFLT |=> temp_warn) else $error("no warning");
  chk_age_off: assert property (!f_qage |=> !q_fifo_mode)
    else $error("aging while off");
  chk_xmode_seq: assert property (seek_exercise |->
    $past(xs_ff == XS_RUN)) else $error("exercise early");

endmodule // dmpp_top

// ---- tb/dmpp_host.sv ----
/*
  Initiator model: mode select and mode sense byte access on the
  parameter port, plus stop unit and start unit events.
  Assumes a free-running clk_sys; drives 1 ns after each rising edge.
*/
`timescale 1ns/1ps
module dmpp_host (
  // Clock
  input  wire logic       clk_sys,
  // Parameter port
  output logic            par_wr,
  output logic      [7:0] par_page,
  output logic      [3:0] par_idx,
  output logic      [7:0] par_wdata,
  input  wire logic [7:0] par_rdata,
  // Unit commands
  output logic            spin_stop,
  output logic            spin_start
);
  initial begin
    par_wr     = 1'b0;
    par_page   = 8'h00;
    par_idx    = 4'h0;
    par_wdata  = 8'h00;
    spin_stop  = 1'b0;
    spin_start = 1'b0;
  end

  // ==========================================================
  // Mode select and mode sense, one byte each
  task automatic wr(input logic [7:0] pg, input logic [3:0] ix,
                    input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    par_wr    = 1'b1;
    par_page  = pg;
    par_idx   = ix;
    par_wdata = d;
    @(posedge clk_sys);
    #1;
    par_wr    = 1'b0;
    // Released data must not look valid
    par_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] pg, input logic [3:0] ix,
                    output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    par_page = pg;
    par_idx  = ix;
    // Take the byte once it has settled, not at its launching edge
    @(posedge clk_sys);
    #1;
    d = par_rdata;
  endtask

  // ==========================================================
  // Stop unit then start unit, after the exercise bit was set
  task automatic unit_cycle();
    @(posedge clk_sys);
    #1;
    spin_stop = 1'b1;
    @(posedge clk_sys);
    #1;
    spin_stop = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    spin_start = 1'b1;
    @(posedge clk_sys);
    #1;
    spin_start = 1'b0;
  endtask
endmodule  // dmpp_host

// ---- tb/testbench.sv ----
/*
  Self-checking bench for dmpp_top: registers through the host model,
  then policy cases as call sequences. Assumes TICK_CYC set to 20.
*/
`timescale 1ns/1ps
module testbench;
  import dmpp_pkg::*;
  localparam int TK = 20;
  logic        clk_sys, arst_n, par_wr, spinning, spin_stop, spin_start;
  logic        q_push, q_pop, cmd_start, cmd_rw, cmd_done, rec_evt;
  logic        fmt_degraded, cmd_is_tur, q_fifo_mode, cmd_abort, rec_post;
  logic        tur_report_degraded, temp_warn, fmt_merge, fmt_no_write;
  logic        fmt_certify, reassign_restore, skip_reassigned;
  logic        seek_exercise;
  logic [1:0]  q_push_slot, q_pop_slot, q_fifo_slot, rec_kind;
  logic [3:0]  par_idx, cmd_sense_key;
  logic [7:0]  par_page, par_wdata, par_rdata, rec_step, temp_c;
  logic [7:0]  read_retry_max, write_retry_max, rd_d;
  logic [15:0] recovery_time_limit;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;

  dmpp_top #(.TICK_CYC(TK)) i_dmpp_top (.clk_sys, .arst_n, .par_wr,
    .par_page, .par_idx, .par_wdata, .par_rdata, .spinning, .spin_stop,
    .spin_start, .q_push, .q_push_slot, .q_pop, .q_pop_slot, .q_fifo_mode,
    .q_fifo_slot, .cmd_start, .cmd_rw, .cmd_done, .cmd_abort,
    .cmd_sense_key, .rec_evt, .rec_kind, .rec_step, .rec_post,
    .fmt_degraded, .cmd_is_tur, .temp_c, .tur_report_degraded, .temp_warn,
    .fmt_merge, .fmt_no_write, .fmt_certify, .reassign_restore,
    .skip_reassigned, .seek_exercise, .read_retry_max, .write_retry_max,
    .recovery_time_limit);
  dmpp_host i_dmpp_host (.clk_sys, .par_wr, .par_page, .par_idx,
    .par_wdata, .par_rdata, .spin_stop, .spin_start);

  // ==========================================================
  // Helpers
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic cy(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [7:0] pg, ix, d);
    i_dmpp_host.wr(pg, ix[3:0], d);
    cy(2);
  endtask

  task automatic rc(input logic [7:0] pg, ix, e, input string m);
    i_dmpp_host.rd(pg, ix[3:0], rd_d);
    chk(rd_d, e, m);
  endtask

  task automatic re(input logic [1:0] k, input logic [7:0] s,
                    input logic e);
    logic p;
    rec_evt  = 1'b1;
    rec_kind = k;
    rec_step = s;
    cy(1);
    rec_evt = 1'b0;
    p = rec_post;
    cy(1);
    chk(p | rec_post, e, "post");
  endtask

  task automatic cmd(input logic rw, ea);
    int n;
    n = 0;
    cmd_start = 1'b1;
    cmd_rw    = rw;
    cy(1);
    cmd_start = 1'b0;
    while (cmd_abort !== 1'b1 && n < 5*TK) begin
      cy(1);
      n++;
    end
    if (ea) begin
      chk(n >= 2*TK && n <= 4*TK+4, 1'b1, "abort time");
      cy(1);
      chk({cmd_abort, cmd_sense_key}, {1'b0, SK_ABORTED}, "abort key");
    end else begin
      chk(n, 5*TK, "no abort");
      cmd_done = 1'b1;
      cy(1);
      cmd_done = 1'b0;
    end
  endtask

  task automatic tw(input logic [7:0] t, input logic e);
    temp_c = t;
    cy(2);
    chk(temp_warn, e, "temp");
  endtask

  // ==========================================================
  // Clock, reset and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      $display("unexpected at %0t: timeout", $time);
      report_and_stop();
    end
  end

  // ==========================================================
  // Test sequence
  initial begin
    {arst_n, spinning, q_push, q_pop, cmd_start, cmd_rw} = 6'h00;
    {cmd_done, rec_evt, fmt_degraded, cmd_is_tur} = 4'h0;
    {q_push_slot, q_pop_slot, rec_kind, rec_step} = 14'h0000;
    temp_c = 8'h14;
    repeat (8) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    cy(1);
    chk({reassign_restore, read_retry_max, write_retry_max},
        {1'b1, DFLT_READ_RETRY, 8'h01}, "reset outputs");
    for (int i = 0; i < 16; i++) begin
      rc(PG_VENDOR, i, i < 2 ? {PS_FLAG, P0_LEN} >> (8 - 8*i)
         : P0_RST[i*8 +: 8], "p0 reset");
      wr(PG_VENDOR, i, 8'hff);
      rc(PG_VENDOR, i, i < 2 ? {PS_FLAG, P0_LEN} >> (8 - 8*i)
         : P0_MASK[i*8 +: 8], "p0 mask");
      wr(PG_VENDOR, i, P0_RST[i*8 +: 8]);
    end
    for (int i = 0; i < 13; i++) begin
      rc(PG_RECOV, i, i < 2 ? {PS_FLAG | PG_RECOV, P1_LEN} >> (8 - 8*i)
         : P1_RST[i*8 +: 8], "p1 reset");
      wr(PG_RECOV, i, 8'hff);
      rc(PG_RECOV, i, i < 2 ? {PS_FLAG | PG_RECOV, P1_LEN} >> (8 - 8*i)
         : P1_MASK[i*8 +: 8], "p1 mask");
      wr(PG_RECOV, i, P1_RST[i*8 +: 8]);
    end
    rc(8'h02, 8'h03, 8'h00, "unknown page");
    $display("test registers done");
    wr(PG_VENDOR, 8'h02, 8'h08);
    chk(fmt_merge, 1'b1, "merge");
    wr(PG_VENDOR, 8'h0e, 8'h88);
    chk({reassign_restore, fmt_no_write}, 2'b01, "reassign fmt");
    wr(PG_VENDOR, 8'h0f, 8'h20);
    chk(fmt_certify, 1'b1, "certify");
    wr(PG_VENDOR, 8'h02, 8'h01);
    wr(PG_VENDOR, 8'h0e, 8'h00);
    wr(PG_VENDOR, 8'h0f, 8'h00);
    chk({fmt_merge, reassign_restore, fmt_no_write, fmt_certify}, 4'h4,
        "format clear");
    for (int k = 0; k < 4; k++) begin
      wr(PG_VENDOR, 8'h06, {k[1], 7'h00});
      wr(PG_RECOV, 8'h02, {3'h0, k[0], 4'h0});
      chk(skip_reassigned, k == 3, "skip");
    end
    wr(PG_VENDOR, 8'h06, 8'h40);
    wr(PG_RECOV, 8'h03, 8'h05);
    chk(read_retry_max, 8'h05, "bounded");
    wr(PG_VENDOR, 8'h06, 8'h00);
    chk(read_retry_max, DFLT_READ_RETRY, "builtin");
    wr(PG_RECOV, 8'h03, 8'h00);
    chk(read_retry_max, 8'h00, "zero count");
    wr(PG_RECOV, 8'h08, 8'h07);
    wr(PG_RECOV, 8'h0a, 8'h12);
    wr(PG_RECOV, 8'h0b, 8'h34);
    chk(write_retry_max, 8'h07, "wr limit");
    chk(recovery_time_limit, 16'h1234, "time limit");
    $display("test retry done");
    re(RK_READ, 8'hff, 1'b0);
    wr(PG_RECOV, 8'h02, 8'h04);
    re(RK_READ, 8'h16, 1'b0);
    re(RK_READ, 8'h17, 1'b1);
    re(RK_WRITE, 8'h14, 1'b0);
    re(RK_WRITE, 8'h15, 1'b1);
    re(RK_NDATA, 8'h01, 1'b0);
    wr(PG_VENDOR, 8'h03, 8'h10);
    re(RK_NDATA, 8'h01, 1'b1);
    wr(PG_VENDOR, 8'h03, 8'h00);
    $display("test recovered done");
    tw(8'h54, 1'b0);
    tw(8'h55, 1'b1);
    wr(PG_VENDOR, 8'h09, 8'h28);
    tw(8'h27, 1'b0);
    tw(8'h28, 1'b1);
    fmt_degraded = 1'b1;
    cmd_is_tur   = 1'b1;
    cy(2);
    chk(tur_report_degraded, 1'b1, "degraded");
    wr(PG_VENDOR, 8'h05, 8'h12);
    chk(tur_report_degraded, 1'b0, "suppressed");
    wr(PG_VENDOR, 8'h05, 8'h02);
    cmd_is_tur = 1'b0;
    cy(2);
    chk(tur_report_degraded, 1'b0, "media access");
    $display("test status done");
    wr(PG_VENDOR, 8'h07, 8'h03);
    cmd(1'b1, 1'b1);
    cmd(1'b0, 1'b0);
    wr(PG_VENDOR, 8'h07, 8'h00);
    cmd(1'b1, 1'b0);
    $display("test timer done");
    wr(PG_VENDOR, 8'h0b, 8'h02);
    q_push      = 1'b1;
    q_push_slot = 2'd2;
    cy(1);
    q_push_slot = 2'd1;
    cy(1);
    q_push = 1'b0;
    cy(TK);
    chk(q_fifo_mode, 1'b0, "young");
    for (int n = 0; n < 3*TK+4 && q_fifo_mode !== 1'b1; n++) cy(1);
    chk({q_fifo_mode, q_fifo_slot}, 3'b110, "aged");
    wr(PG_VENDOR, 8'h05, 8'h00);
    chk(q_fifo_mode, 1'b0, "aging off");
    q_pop      = 1'b1;
    q_pop_slot = 2'd2;
    cy(1);
    q_pop_slot = 2'd1;
    cy(1);
    q_pop = 1'b0;
    $display("test queue done");
    spinning = 1'b1;
    wr(PG_VENDOR, 8'h03, 8'h40);
    i_dmpp_host.unit_cycle();
    cy(2);
    chk(seek_exercise, 1'b1, "exercise");
    wr(PG_VENDOR, 8'h03, 8'h00);
    chk(seek_exercise, 1'b0, "exercise off");
    $display("test exercise done");
    report_and_stop();
  end
endmodule  // testbench
